//--- include/svrw_params.svh
`ifndef SVRW_PARAMS_SVH
`define SVRW_PARAMS_SVH

// ----------------------------------------------------------------
// timing figures and clock rate
// ----------------------------------------------------------------
`define SVRW_CLK_HZ          200000000
`define SVRW_RST_REL_MS      200
`define SVRW_WDOG_TMO_MS     1560
`define SVRW_RST_REL_CYC     ((`SVRW_CLK_HZ / 1000) * `SVRW_RST_REL_MS)
`define SVRW_WDOG_TMO_CYC    ((`SVRW_CLK_HZ / 1000) * `SVRW_WDOG_TMO_MS)

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define SVRW_CNT_W           32
`define SVRW_SYNC_STAGES     2
`define SVRW_FLAG_RST        1'b1
`define SVRW_PIN_IDLE        1'b1

`endif

//--- include/svrw_pkg.sv
package svrw_pkg;

   typedef enum logic [1:0]
   {
      SVRW_HOLD,
      SVRW_TIMING,
      SVRW_RUN
   } svrw_rst_state_t;

   typedef logic [31:0] svrw_cnt_t;

endpackage : svrw_pkg

//--- hdl/svrw_sync.sv
`timescale 1ns/1ps
`include "svrw_params.svh"

module svrw_sync
#(
   parameter logic RST_VAL = `SVRW_FLAG_RST
)
(
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_async,
   output logic      o_sync
);

   logic meta_ff;

   // ----------------------------------------------------------------
   // two-stage synchroniser; first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         meta_ff <= RST_VAL;
         o_sync  <= RST_VAL;
      end
      else
      begin
         meta_ff <= i_async;
         o_sync  <= meta_ff;
      end
   end

endmodule : svrw_sync

//--- hdl/svrw_timer.sv
`timescale 1ns/1ps
`include "svrw_params.svh"

module svrw_timer
#(
   parameter int unsigned TERM = 10
)
(
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_clear,
   output logic      o_done
);
   import svrw_pkg::*;

   svrw_cnt_t cnt_ff;

   // ----------------------------------------------------------------
   // saturating count; clear wins, done once TERM cycles have passed
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n || i_clear)
         cnt_ff <= '0;
      else if (cnt_ff < svrw_cnt_t'(TERM))
         cnt_ff <= cnt_ff + 32'h1;
   end

   assign o_done = (cnt_ff >= svrw_cnt_t'(TERM));

endmodule : svrw_timer

//--- hdl/svrw_top.sv
`timescale 1ns/1ps
`include "svrw_params.svh"

// What this block does
// - reset held while supply low, released 200 ms after it clears
// - supply dropping low in operation asserts reset at once
// - brownout during reset restarts the release timer
// - reset held from power-up through the rise until timer expires
// - reset held continuously on power-down while supply stays low
// - active-high reset is always the inverse of active-low reset
// - adjustable variant uses trip-level sense flag instead of supply
// - kick must toggle within timeout, else fault output goes low
// - fault output low whenever supply is low, no minimum width
// - fault output goes high at once when supply clears and the watchdog has not timed out
// - power-fail warning low while sense below reference
// - power-fail path fully independent of other logic
// - low-line warning from its own flag, high in normal operation
// - reset held while manual reset low and 200 ms afterwards
// - unconnected manual reset counts as inactive high
// - bouncing manual reset gives one stretched reset
// - every kick edge clears watchdog; timeout after 1.56 s idle
// - low-line warning returns high at once when its own flag clears

module svrw_top
#(
   parameter bit          HAS_WDOG     = 1'b1,
   parameter bit          HAS_LOW_LINE = 1'b1,
   parameter bit          HAS_RST_HI   = 1'b1,
   parameter bit          ADJ_TRIP     = 1'b0,
   parameter int unsigned REL_CYC      = `SVRW_RST_REL_CYC,
   parameter int unsigned WDOG_CYC     = `SVRW_WDOG_TMO_CYC
)
(
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_supply_low,
   input  wire logic i_reset_trip_level_low,
   input  wire logic i_manual_reset_n,
   input  wire logic i_watchdog_kick_in,
   input  wire logic i_power_fail_sense_low,
   input  wire logic i_low_line_low,
   output logic      o_reset_n,
   output logic      o_reset,
   output logic      o_watchdog_fault_n,
   output logic      o_power_fail_warn_n,
   output logic      o_low_line_n
);
   import svrw_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic supply_low_s;
   logic trip_low_s;
   logic mr_n_s;
   logic kick_s;
   logic pf_low_s;
   logic ll_low_s;

   // supply flags come up "low" so reset holds from power-up
   svrw_sync #(.RST_VAL(`SVRW_FLAG_RST)) u_sync_sup
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    (i_supply_low),
      .o_sync     (supply_low_s)
   );

   svrw_sync #(.RST_VAL(`SVRW_FLAG_RST)) u_sync_trip
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    (i_reset_trip_level_low),
      .o_sync     (trip_low_s)
   );

   // pull-up modelled by idle-high reset value
   svrw_sync #(.RST_VAL(`SVRW_PIN_IDLE)) u_sync_mr
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    (i_manual_reset_n),
      .o_sync     (mr_n_s)
   );

   svrw_sync #(.RST_VAL(`SVRW_PIN_IDLE)) u_sync_kick
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    (i_watchdog_kick_in),
      .o_sync     (kick_s)
   );

   svrw_sync #(.RST_VAL(`SVRW_FLAG_RST)) u_sync_pf
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    (i_power_fail_sense_low),
      .o_sync     (pf_low_s)
   );

   svrw_sync #(.RST_VAL(`SVRW_FLAG_RST)) u_sync_ll
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    (i_low_line_low),
      .o_sync     (ll_low_s)
   );

   // ----------------------------------------------------------------
   // reset source and release timer
   // ----------------------------------------------------------------
   logic trip_low;
   logic rst_cause;
   logic rel_done;

   assign trip_low  = ADJ_TRIP ? trip_low_s : supply_low_s;
   // any cause, including each bounce low, restarts the timer, so a
   // bouncing switch yields one stretched reset
   assign rst_cause = trip_low | ~mr_n_s;

   svrw_timer #(.TERM(REL_CYC)) u_rel_tmr
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_clear    (rst_cause),
      .o_done     (rel_done)
   );

   svrw_rst_state_t state_ff;
   svrw_rst_state_t nxt_state;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         SVRW_HOLD:
            if (!rst_cause)
               nxt_state = SVRW_TIMING;
         SVRW_TIMING:
            if (rst_cause)
               nxt_state = SVRW_HOLD;
            else if (rel_done)
               nxt_state = SVRW_RUN;
         SVRW_RUN:
            if (rst_cause)
               nxt_state = SVRW_HOLD;
         default:
            nxt_state = SVRW_HOLD;
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         state_ff <= SVRW_HOLD;
      else
         state_ff <= nxt_state;
   end

   // reset held in HOLD and TIMING; low supply forces HOLD
   logic nxt_reset_n;
   assign nxt_reset_n = (nxt_state == SVRW_RUN);

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         o_reset_n <= 1'b0;
         o_reset   <= HAS_RST_HI;
      end
      else
      begin
         o_reset_n <= nxt_reset_n;
         // both taken from the same term so they never disagree
         o_reset   <= HAS_RST_HI & ~nxt_reset_n;
      end
   end

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   logic kick_d_ff;
   logic kick_edge;
   logic wdog_done;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         kick_d_ff <= `SVRW_PIN_IDLE;
      else
         kick_d_ff <= kick_s;
   end

   assign kick_edge = kick_s ^ kick_d_ff;

   // the watchdog runs independently of reset; only kicks clear it
   svrw_timer #(.TERM(WDOG_CYC)) u_wdog_tmr
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_clear    (kick_edge),
      .o_done     (wdog_done)
   );

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         o_watchdog_fault_n <= 1'b0;
      else if (!HAS_WDOG)
         o_watchdog_fault_n <= `SVRW_PIN_IDLE;
      else
         // no stretch: follows trip_low directly
         o_watchdog_fault_n <= ~(trip_low | wdog_done);
   end

   // ----------------------------------------------------------------
   // power-fail and low-line warnings
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         o_power_fail_warn_n <= 1'b0;
      else
         // own path, touches nothing else
         o_power_fail_warn_n <= ~pf_low_s;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         o_low_line_n <= 1'b0;
      else if (!HAS_LOW_LINE)
         o_low_line_n <= `SVRW_PIN_IDLE;
      else
         // hysteresis lives in the analogue flag; no delay on return
         o_low_line_n <= ~ll_low_s;
   end

endmodule : svrw_top

//--- dv/svrw_chk.sv
`timescale 1ns/1ps
module svrw_chk
#(
   parameter int unsigned REL_CYC  = 20,
   parameter int unsigned WDOG_CYC = 50,
   parameter bit          ADJ_TRIP = 1'b0
)
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_supply_low,
   input wire logic i_reset_trip_level_low,
   input wire logic i_manual_reset_n,
   input wire logic i_watchdog_kick_in,
   input wire logic i_power_fail_sense_low,
   input wire logic o_reset_n,
   input wire logic o_reset,
   input wire logic o_watchdog_fault_n,
   input wire logic o_power_fail_warn_n
);
   // ------
   // cycles since the last reset cause and the last kick edge
   // ------
   int   quiet_ff;
   int   age_ff;
   logic kick_ff;
   logic trip_low;
   // the adjustable variant trips on its sense input, not the supply
   assign trip_low = ADJ_TRIP ? i_reset_trip_level_low : i_supply_low;
   always_ff @(posedge i_core_clk)
   begin
      kick_ff  <= i_watchdog_kick_in;
      quiet_ff <= (!i_rst_n || trip_low || !i_manual_reset_n) ? 0
                  : quiet_ff + int'(quiet_ff < 1000);
      age_ff   <= (!i_rst_n || i_watchdog_kick_in != kick_ff) ? 0
                  : age_ff + int'(age_ff < 1000);
   end
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_brown;
      $rose(trip_low);
   endsequence
   a_rst_inverse:
      assert property (o_reset == !o_reset_n)
      else $error("high reset not inverse of low reset");
   a_brown_rst:
      assert property (s_brown |-> ##[1:4] !o_reset_n)
      else $error("brownout did not assert reset");
   a_mr_rst:
      assert property (!i_manual_reset_n [*4] |-> !o_reset_n)
      else $error("manual reset not honoured");
   a_rel_early:
      assert property ($rose(o_reset_n) |-> quiet_ff >= REL_CYC)
      else $error("reset released early");
   a_rel_late:
      assert property (quiet_ff == REL_CYC + 8 |-> o_reset_n)
      else $error("reset released late");
   a_supply_wdo:
      assert property (trip_low [*4] |-> !o_watchdog_fault_n)
      else $error("fault high with supply low");
   a_wdo_rise:
      assert property ($fell(trip_low) && age_ff < WDOG_CYC - 8
                       |-> ##[1:4] o_watchdog_fault_n)
      else $error("fault stuck low after supply cleared");
   a_wdog_tmo:
      assert property (age_ff == WDOG_CYC + 8 |-> !o_watchdog_fault_n)
      else $error("watchdog did not time out");
   a_pf_low:
      assert property (i_power_fail_sense_low [*4] |-> !o_power_fail_warn_n)
      else $error("power fail warning missing");
endmodule : svrw_chk

bind svrw_top svrw_chk #(.REL_CYC(REL_CYC), .WDOG_CYC(WDOG_CYC),
                         .ADJ_TRIP(ADJ_TRIP)) chk_u (.*);

//--- dv/svrw_cpu.sv
`timescale 1ns/1ps
module svrw_cpu
#(
   parameter int unsigned KICK_CYC = 20
)
(
   input  wire logic i_core_clk,
   input  wire logic i_hang,
   input  wire logic i_btn_n,
   input  wire logic i_fault_n,
   output logic      o_kick,
   output logic      o_mr_n
);
   int cnt = 0;
   initial o_kick = 1'b0;
   // a hung program simply stops toggling
   always @(negedge i_core_clk)
   begin
      cnt = (cnt + 1) % KICK_CYC;
      if (!i_hang && cnt == 0)
         o_kick <= !o_kick;
   end
   assign o_mr_n = i_btn_n & i_fault_n;
endmodule : svrw_cpu

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_supply_low = 1'b1;
   logic i_reset_trip_level_low = 1'b0;
   logic i_power_fail_sense_low = 1'b1;
   logic i_low_line_low = 1'b1;
   logic btn_n = 1'b1;
   logic hang = 1'b0;
   logic sb_on = 1'b0;
   logic i_manual_reset_n, i_watchdog_kick_in, o_reset_n, o_reset;
   logic o_watchdog_fault_n, o_power_fail_warn_n, o_low_line_n;
   logic adj_rst_n, adj_ll_n;
   logic q_pf[$];
   logic q_ll[$];
   int   n_fail = 0;
   int   checks = 0;
   int   cyc = 0;
   int   seed = 32'h152992d9;
   int   r;

   always #2.5 i_core_clk = ~i_core_clk;

   svrw_top #(.REL_CYC(20), .WDOG_CYC(50)) dut_u (.*);
   svrw_cpu #(.KICK_CYC(20)) cpu_u
   (
      .i_core_clk (i_core_clk),
      .i_hang     (hang),
      .i_btn_n    (btn_n),
      .i_fault_n  (o_watchdog_fault_n),
      .o_kick     (i_watchdog_kick_in),
      .o_mr_n     (i_manual_reset_n)
   );
   // adjustable variant: supply flag stuck low must be ignored
   svrw_top #(.REL_CYC(20), .WDOG_CYC(50), .ADJ_TRIP(1'b1),
              .HAS_LOW_LINE(1'b0)) dut_adj_u
   (
      .i_core_clk             (i_core_clk),
      .i_rst_n                (i_rst_n),
      .i_supply_low           (1'b1),
      .i_reset_trip_level_low (i_supply_low),
      .i_manual_reset_n       (btn_n),
      .i_watchdog_kick_in     (i_watchdog_kick_in),
      .i_power_fail_sense_low (i_power_fail_sense_low),
      .i_low_line_low         (i_low_line_low),
      .o_reset_n              (adj_rst_n),
      .o_reset                (),
      .o_watchdog_fault_n     (),
      .o_power_fail_warn_n    (),
      .o_low_line_n           (adj_ll_n)
   );

   task automatic check(input logic seen, input logic exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic cyc_n(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask : cyc_n

   task automatic cause(input bit mr, input int n);
      if (mr)
         btn_n = 1'b0;
      else
         i_supply_low = 1'b1;
      cyc_n(n);
      check(o_reset_n, 1'b0);
      check(o_reset, 1'b1);
      check(adj_rst_n, 1'b0);
      if (!mr)
         check(o_watchdog_fault_n, 1'b0);
      btn_n = 1'b1;
      i_supply_low = 1'b0;
   endtask : cause

   task automatic expect_rel;
      cyc_n(18);
      check(o_reset_n, 1'b0);
      cyc_n(14);
      check(o_reset_n, 1'b1);
      check(o_watchdog_fault_n, 1'b1);
      check(adj_rst_n, 1'b1);
   endtask : expect_rel

   always @(o_power_fail_warn_n)
      if (sb_on)
         check(o_power_fail_warn_n, q_pf.pop_front());
   always @(o_low_line_n)
      if (sb_on)
         check(o_low_line_n, q_ll.pop_front());

   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         stop_test();
      end
   end

   initial
   begin
      cyc_n(5);
      i_rst_n = 1'b1;
      cause(1'b0, 10);
      expect_rel();
      cause(1'b0, 5);
      cyc_n(8);
      cause(1'b0, 4);
      expect_rel();
      cause(1'b1, 6);
      expect_rel();
      repeat (4)
      begin
         cyc_n(3);
         cause(1'b1, 4);
      end
      expect_rel();
      hang = 1'b1;
      cyc_n(60);
      check(o_watchdog_fault_n, 1'b0);
      check(o_reset_n, 1'b0);
      check(adj_rst_n, 1'b1);
      hang = 1'b0;
      cyc_n(26);
      check(o_watchdog_fault_n, 1'b1);
      cyc_n(40);
      sb_on = 1'b1;
      repeat (30)
      begin
         r = $random(seed);
         i_power_fail_sense_low ^= r[0];
         i_low_line_low ^= r[4];
         if (r[0])
            q_pf.push_back(!i_power_fail_sense_low);
         if (r[4])
            q_ll.push_back(!i_low_line_low);
         cyc_n(4 + r[3:1]);
      end
      cyc_n(6);
      check(q_pf.size() == 0, 1'b1);
      check(q_ll.size() == 0, 1'b1);
      check(o_reset_n, 1'b1);
      check(adj_ll_n, 1'b1);
      stop_test();
   end
endmodule : testbench
